// File: pkg/dowd_pkg.sv
// dowd_pkg: constants for the device option word decoder
// assumes: a 12-bit option word arrives from non-volatile storage
`default_nettype none
package dowd_pkg;

  localparam int unsigned         DOWD_WORD_W        = 12;
  // register indices (offsets chosen; word and status registers)
  localparam logic [3:0]          DOWD_ADDR_WORD     = 4'h0;
  localparam logic [3:0]          DOWD_ADDR_STATUS   = 4'h1;
  // field positions
  localparam int unsigned         DOWD_POS_UNIMP_HI  = 11;
  localparam int unsigned         DOWD_POS_UNIMP_LO  = 5;
  localparam int unsigned         DOWD_POS_RST_SEL   = 4;
  localparam int unsigned         DOWD_POS_RDPROT_N  = 3;
  localparam int unsigned         DOWD_POS_WDOG_ON   = 2;
  localparam int unsigned         DOWD_POS_RSVD_HI   = 1;
  localparam int unsigned         DOWD_POS_RSVD_LO   = 0;
  // bits forced to one on readback
  localparam logic [11:0]         DOWD_FORCE_ONES    = 12'hFE3;
  // safe reset value: external reset on, unprotected, watchdog on
  localparam logic [11:0]         DOWD_RESET_WORD    = 12'hFFF;

  typedef enum logic [1:0] {
    DOWD_ST_RESET,
    DOWD_ST_LOADED
  } dowd_state_e;

endpackage
`default_nettype wire

// File: rtl/dowd_sync.sv
// dowd_sync: two-flop synchroniser for one pin level
// assumes: input is asynchronous to ref_clk
`timescale 1ns/1ns
`default_nettype none
module dowd_sync (
  input  wire logic ref_clk,
  input  wire logic rstn,
  input  wire logic din,
  output logic      dout
);
  logic meta_r;

  // first flop only feeds the second
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      meta_r <= 1'b1;
      dout   <= 1'b1;
    end else begin
      meta_r <= din;
      dout   <= meta_r;
    end
  end
endmodule
`default_nettype wire

// File: rtl/dowd_readback.sv
// dowd_readback: forms the readback view of the option word
// assumes: word input is the captured word, steady after reset
`timescale 1ns/1ns
`default_nettype none
module dowd_readback
  import dowd_pkg::*;
(
  input  wire logic [11:0] word,
  output logic [11:0]      view
);
  // unimplemented and reserved positions read one
  always_comb begin
    view = word | DOWD_FORCE_ONES;
  end
endmodule
`default_nettype wire

// File: rtl/dowd_top.sv
// dowd_top: device option word decoder
// assumes: option word is steady from storage during reset; reg port on ref_clk
//
// Decided for this implementation: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
module dowd_top
  import dowd_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic [11:0] nv_word,
  input  wire logic        shared_reset_io_pin_in,
  input  wire logic        io_out,
  input  wire logic        io_oe,
  output logic             shared_reset_io_pin_out,
  output logic             shared_reset_io_pin_oe,
  output logic             io_in,
  output logic             external_reset_input_n,
  output logic             read_protect_on,
  output logic             watchdog_on,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [15:0]      reg_rdata
);

  //////////////////////////////////////////////////////////////////////////////
  logic [11:0]  word_r;
  logic [11:0]  view;
  logic         pin_sync;
  dowd_state_e  state_r;

  // capture on the first edge after reset release; word is held from then on
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= DOWD_ST_RESET;
    end else begin
      state_r <= DOWD_ST_LOADED;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      word_r <= DOWD_RESET_WORD;
    end else begin
      case (state_r)
        DOWD_ST_RESET: begin
          word_r <= nv_word;
        end
        default: begin
          word_r <= word_r;
        end
      endcase
    end
  end

  // decoded controls hold their safe state (protected, watchdog on, pin as reset input) until the word is loaded
  logic loaded;
  assign loaded = (state_r == DOWD_ST_LOADED);

  //////////////////////////////////////////////////////////////////////////////
  dowd_sync u_sync (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .din     (shared_reset_io_pin_in),
    .dout    (pin_sync)
  );

  logic rst_sel;
  assign rst_sel = word_r[DOWD_POS_RST_SEL];

  // as reset input the pin is never driven; reset held inactive otherwise
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      external_reset_input_n  <= 1'b1;
      io_in                   <= 1'b0;
      shared_reset_io_pin_out <= 1'b0;
      shared_reset_io_pin_oe  <= 1'b0;
    end else if (rst_sel || !loaded) begin
      external_reset_input_n  <= pin_sync;
      io_in                   <= 1'b0;
      shared_reset_io_pin_out <= 1'b0;
      shared_reset_io_pin_oe  <= 1'b0;
    end else begin
      external_reset_input_n  <= 1'b1;
      io_in                   <= pin_sync;
      shared_reset_io_pin_out <= io_out;
      shared_reset_io_pin_oe  <= io_oe;
    end
  end

  // hold the protected, watchdog-on state until the captured word is in
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      read_protect_on <= 1'b1;
      watchdog_on     <= 1'b1;
    end else if (loaded) begin
      read_protect_on <= ~word_r[DOWD_POS_RDPROT_N];
      watchdog_on     <= word_r[DOWD_POS_WDOG_ON];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  dowd_readback u_rb (
    .word (word_r),
    .view (view)
  );

  // word is read-only once loaded; writes are ignored to true
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      if (reg_addr == DOWD_ADDR_WORD) begin
        reg_rdata <= {4'h0, view};
      end else if (reg_addr == DOWD_ADDR_STATUS) begin
        reg_rdata <= {15'h0, loaded};
      end else begin
        reg_rdata <= 16'h0000;
      end
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  logic unused_w;
  assign unused_w = reg_wr ^ (^reg_wdata);

endmodule
`default_nettype wire

// File: test/dowd_checker.sv
// dowd_checker: port checks for the option word decoder
// assumes: bound to dowd_top, one ref_clk domain
`timescale 1ns/1ns
`default_nettype none
module dowd_checker (
  input wire logic        ref_clk,
  input wire logic        rstn,
  input wire logic        reg_rd,
  input wire logic [3:0]  reg_addr,
  input wire logic [15:0] reg_rdata,
  input wire logic        io_in,
  input wire logic        external_reset_input_n,
  input wire logic        read_protect_on,
  input wire logic        watchdog_on,
  input wire logic        shared_reset_io_pin_out,
  input wire logic        shared_reset_io_pin_oe
);
  // age waits out capture and decode edges
  logic [1:0] age_r;
  always_ff @(posedge ref_clk or negedge rstn)
    if (!rstn) age_r <= 2'h0;
    else if (age_r != 2'h3) age_r <= age_r + 2'h1;
  wire rd0 = age_r == 2'h3 && reg_rd && reg_addr == 4'h0;
  ////////////////////////////////////////////////////////////
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  chk_unimp_ones: assert property (rd0 |=> reg_rdata[11:5] == 7'h7F)
    else $error("upper bits not ones");
  chk_rsvd_ones: assert property (rd0 |=> reg_rdata[1:0] == 2'h3)
    else $error("low bits not ones");
  chk_pin_mode: assert property (rd0 |=> (reg_rdata[4] ? !io_in : external_reset_input_n))
    else $error("pin mode wrong");
  chk_protect_low: assert property (rd0 |=> read_protect_on == !reg_rdata[3])
    else $error("protect polarity wrong");
  chk_wdog_on: assert property (rd0 |=> watchdog_on == reg_rdata[2])
    else $error("watchdog wrong");
  chk_hold_const: assert property (age_r == 2'h3 |-> $stable({read_protect_on, watchdog_on}))
    else $error("outputs moved");
  chk_safe_load: assert property (age_r == 2'h1 |-> read_protect_on && watchdog_on)
    else $error("controls left safe state early");
  chk_pin_undriven: assert property (rd0 ##1 reg_rdata[4] |-> !shared_reset_io_pin_oe)
    else $error("reset pin driven");
  cover property (rd0);
  cover property (rd0 ##1 reg_rdata[4]);
  cover property (rd0 ##1 !reg_rdata[3]);
endmodule
bind dowd_top dowd_checker chk_u (.ref_clk, .rstn, .reg_rd, .reg_addr, .reg_rdata, .io_in,
  .external_reset_input_n, .read_protect_on, .watchdog_on,
  .shared_reset_io_pin_out, .shared_reset_io_pin_oe);
`default_nettype wire

// File: test/tb_top.sv
// tb_top: scenario tasks for the option word decoder
// assumes: dowd_pkg and rtl compiled first
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import dowd_pkg::*;
;
  logic        ref_clk = 0, rstn = 0, pin = 1, wr = 0, rd = 0;
  logic [11:0] nvw = 12'h000;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wd = 16'h0000, rdata, got;
  logic        io_in, ext_n, prot, wdog;
  logic        io_o = 0, io_e = 0, pin_o, pin_e;
  int          failures = 0, tests_run = 0;
  dowd_top dut_u (.ref_clk, .rstn, .nv_word(nvw), .shared_reset_io_pin_in(pin),
    .io_out(io_o), .io_oe(io_e),
    .shared_reset_io_pin_out(pin_o), .shared_reset_io_pin_oe(pin_e),
    .io_in, .external_reset_input_n(ext_n), .read_protect_on(prot), .watchdog_on(wdog),
    .reg_addr(addr), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata));
  initial forever #25 ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] g, e);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("wrong value t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // word only captured on the first edge after reset release, so each case reboots
  task automatic boot(input logic [11:0] w);
    rstn <= 0;
    nvw <= w;
    repeat (20) @(posedge ref_clk);
    chk({prot, wdog, ext_n, io_in, pin_e}, 5'h1C);
    rstn <= 1;
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic read(input logic [3:0] a);
    rd <= 1;
    addr <= a;
    @(posedge ref_clk);
    rd <= 0;
    @(negedge ref_clk);
    got = rdata;
    @(posedge ref_clk);
  endtask
  // pin needs 3 edges through sync and register
  task automatic drive_pin(input logic v);
    pin <= v;
    repeat (4) @(posedge ref_clk);
  endtask
  // core drive reaches the pin one edge later
  task automatic drive_core(input logic o, e);
    io_o <= o;
    io_e <= e;
    repeat (2) @(posedge ref_clk);
  endtask
  task automatic test_io_mode();
    boot(12'h000);
    read(DOWD_ADDR_WORD);
    chk(got, 16'h0FE3);
    chk({prot, wdog, ext_n}, 3'h5);
    drive_pin(0);
    chk(io_in, 1'b0);
    drive_pin(1);
    chk({io_in, ext_n}, 2'h3);
    drive_core(1, 1);
    chk({pin_o, pin_e}, 2'h3);
    drive_core(0, 1);
    chk({pin_o, pin_e}, 2'h1);
    $display("io mode test done");
  endtask
  task automatic test_reset_mode();
    boot(12'h01C);
    read(DOWD_ADDR_WORD);
    chk(got, 16'h0FFF);
    chk({prot, wdog}, 2'h1);
    drive_pin(0);
    chk({io_in, ext_n}, 2'h0);
    drive_pin(1);
    chk(ext_n, 1'b1);
    drive_core(1, 1);
    chk({pin_o, pin_e}, 2'h0);
    drive_core(0, 0);
    $display("reset mode test done");
  endtask
  task automatic test_hold();
    boot(12'h008);
    nvw <= 12'h014;
    addr <= DOWD_ADDR_WORD;
    wd <= 16'h0014;
    wr <= 1;
    @(posedge ref_clk);
    wr <= 0;
    read(DOWD_ADDR_WORD);
    chk(got, 16'h0FEB);
    chk({prot, wdog}, 2'h0);
    read(DOWD_ADDR_STATUS);
    chk(got, 16'h0001);
    read(4'h5);
    chk(got, 16'h0000);
    $display("hold test done");
  endtask
  task automatic final_report();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    @(posedge ref_clk);
    test_io_mode();
    test_reset_mode();
    test_hold();
    final_report();
  end
endmodule
`default_nettype wire
